// ===== common/mab_defs.svh
// Constants for the multicast address binding block.
`ifndef MAB_DEFS_SVH
`define MAB_DEFS_SVH

`define MAB_EUI_W      48
`define MAB_MCST_W     16
`define MAB_ENTRIES    8
`define MAB_IDX_W      3
`define MAB_OP_W       2
`define MAB_GROUP_BIT  40
`define MAB_NULL_EUI   48'hFFFF_FFFF_FFFF
`define MAB_MCST_BASE  16'hFE00
`define MAB_EUI_ZERO   48'h0000_0000_0000
`define MAB_MCST_ZERO  16'h0000
`define MAB_IDX_ZERO   3'h0

`endif

// ===== common/mab_pkg.sv
// Types shared by the multicast address binding block.
package mab_pkg;

  // Management request codes.
  typedef enum logic [1:0] {
    MAB_OP_REGISTER   = 2'h0,
    MAB_OP_DEREGISTER = 2'h1,
    MAB_OP_ACTIVATE   = 2'h2,
    MAB_OP_DEACTIVATE = 2'h3
  } mab_op_e;

  // Request sequencer states, Gray coded along idle, exec, done.
  typedef enum logic [1:0] {
    MAB_ST_IDLE = 2'h0,
    MAB_ST_EXEC = 2'h1,
    MAB_ST_DONE = 2'h3
  } mab_state_e;

endpackage

// ===== hdl/mab_table.sv
// Binding table: group identifiers, bound flags and receive-active flags.
`timescale 1ns/100ps
`include "mab_defs.svh"

module mab_table (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [`MAB_IDX_W-1:0]    wr_idx,
  input  wire logic [`MAB_EUI_W-1:0]    wr_eui,
  input  wire logic                     wr_bound,
  input  wire logic                     wr_active,
  input  wire logic                     clr_active_all,
  // Request lookup
  input  wire logic [`MAB_EUI_W-1:0]    key_a,
  output logic                          hit_a,
  output logic [`MAB_IDX_W-1:0]         idx_a,
  output logic                          bound_a,
  output logic                          active_a,
  // Transmit lookup
  input  wire logic [`MAB_EUI_W-1:0]    key_t,
  output logic                          bound_t,
  output logic [`MAB_IDX_W-1:0]         idx_t,
  // Receive lookup
  input  wire logic [`MAB_EUI_W-1:0]    key_r,
  output logic                          active_r,
  // Free entry
  output logic                          free_ok,
  output logic [`MAB_IDX_W-1:0]         free_idx
);

  logic [`MAB_EUI_W-1:0] eui      [`MAB_ENTRIES];
  logic                  bound    [`MAB_ENTRIES];
  logic                  active   [`MAB_ENTRIES];
  logic [`MAB_EUI_W-1:0] next_eui    [`MAB_ENTRIES];
  logic                  next_bound  [`MAB_ENTRIES];
  logic                  next_active [`MAB_ENTRIES];

  // Returns {hit, index} of the live entry holding key.
  function automatic logic [`MAB_IDX_W:0] find(
    input logic [`MAB_EUI_W-1:0] key
  );
    logic [`MAB_IDX_W:0] res;
    res = {1'b0, `MAB_IDX_ZERO};
    for (int i = `MAB_ENTRIES - 1; i >= 0; i--) begin
      if ((bound[i] || active[i]) && eui[i] == key) begin
        res = {1'b1, i[`MAB_IDX_W-1:0]};
      end
    end
    return res;
  endfunction

  logic [`MAB_IDX_W:0] fa;
  logic [`MAB_IDX_W:0] ft;
  logic [`MAB_IDX_W:0] fr;

  always_comb begin
    fa       = find(key_a);
    ft       = find(key_t);
    fr       = find(key_r);
    hit_a    = fa[`MAB_IDX_W];
    idx_a    = fa[`MAB_IDX_W-1:0];
    bound_a  = hit_a && bound[idx_a];
    active_a = hit_a && active[idx_a];
    idx_t    = ft[`MAB_IDX_W-1:0];
    bound_t  = ft[`MAB_IDX_W] && bound[idx_t];
    active_r = fr[`MAB_IDX_W] && active[fr[`MAB_IDX_W-1:0]];
    free_ok  = 1'b0;
    free_idx = `MAB_IDX_ZERO;
    for (int i = `MAB_ENTRIES - 1; i >= 0; i--) begin
      if (!bound[i] && !active[i]) begin
        free_ok  = 1'b1;
        free_idx = i[`MAB_IDX_W-1:0];
      end
    end
  end

  // An entry whose bound and active flags are both clear is free again.
  always_comb begin
    for (int i = 0; i < `MAB_ENTRIES; i++) begin
      next_eui[i]    = eui[i];
      next_bound[i]  = bound[i];
      next_active[i] = clr_active_all ? 1'b0 : active[i];
    end
    if (wr_en) begin
      next_eui[wr_idx]    = wr_eui;
      next_bound[wr_idx]  = wr_bound;
      next_active[wr_idx] = wr_active;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MAB_ENTRIES; i++) begin
        eui[i]    <= `MAB_EUI_ZERO;
        bound[i]  <= 1'b0;
        active[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < `MAB_ENTRIES; i++) begin
        eui[i]    <= next_eui[i];
        bound[i]  <= next_bound[i];
        active[i] <= next_active[i];
      end
    end
  end

endmodule

// ===== hdl/mab_top.sv
// Multicast address binding engine: requests, beacon notices, tx and rx.
`timescale 1ns/100ps
`include "mab_defs.svh"

module mab_top (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Management request
  input  wire logic                  req_valid,
  input  wire logic [`MAB_OP_W-1:0]  req_op,
  input  wire logic [`MAB_EUI_W-1:0] req_eui,
  output logic                       req_ready,
  // Management confirm
  output logic                       cfm_valid,
  output logic [`MAB_OP_W-1:0]       cfm_op,
  output logic                       cfm_success,
  // Beacon binding notice
  output logic                       ann_valid,
  output logic                       ann_add,
  output logic [`MAB_EUI_W-1:0]      ann_eui,
  output logic [`MAB_MCST_W-1:0]     ann_mcst,
  // Transmit address lookup
  input  wire logic                  tx_valid,
  input  wire logic [`MAB_EUI_W-1:0] tx_eui,
  output logic                       tx_out_valid,
  output logic                       tx_bound,
  output logic [`MAB_MCST_W-1:0]     tx_dest_mcst,
  // Receive filter
  input  wire logic                  rx_valid,
  input  wire logic [`MAB_EUI_W-1:0] rx_grp_eui,
  output logic                       rx_deliver,
  output logic                       rx_discard
);

  // Short multicast address owned by a table index.
  function automatic logic [`MAB_MCST_W-1:0] mcst_of(
    input logic [`MAB_IDX_W-1:0] idx
  );
    return `MAB_MCST_BASE | {{(`MAB_MCST_W-`MAB_IDX_W){1'b0}}, idx};
  endfunction

  // Sequencer and request state.
  mab_pkg::mab_state_e       state;
  mab_pkg::mab_state_e       next_state;
  mab_pkg::mab_op_e          op;
  mab_pkg::mab_op_e          next_op;
  logic [`MAB_EUI_W-1:0]     eui;
  logic [`MAB_EUI_W-1:0]     next_eui;
  logic                      next_req_ready;
  logic                      next_cfm_valid;
  logic [`MAB_OP_W-1:0]      next_cfm_op;
  logic                      next_cfm_success;
  logic                      next_ann_valid;
  logic                      next_ann_add;
  logic [`MAB_EUI_W-1:0]     next_ann_eui;
  logic [`MAB_MCST_W-1:0]    next_ann_mcst;

  // Table write controls and lookup results.
  logic                      wr_en;
  logic [`MAB_IDX_W-1:0]     wr_idx;
  logic                      wr_bound;
  logic                      wr_active;
  logic                      clr_active_all;
  logic                      hit_a;
  logic [`MAB_IDX_W-1:0]     idx_a;
  logic                      bound_a;
  logic                      active_a;
  logic                      bound_t;
  logic [`MAB_IDX_W-1:0]     idx_t;
  logic                      active_r;
  logic                      free_ok;
  logic [`MAB_IDX_W-1:0]     free_idx;
  logic                      is_group;
  logic                      is_null;

  mab_table u_table (
    .mclk           (mclk),
    .rst            (rst),
    .wr_en          (wr_en),
    .wr_idx         (wr_idx),
    .wr_eui         (eui),
    .wr_bound       (wr_bound),
    .wr_active      (wr_active),
    .clr_active_all (clr_active_all),
    .key_a          (eui),
    .hit_a          (hit_a),
    .idx_a          (idx_a),
    .bound_a        (bound_a),
    .active_a       (active_a),
    .key_t          (tx_eui),
    .bound_t        (bound_t),
    .idx_t          (idx_t),
    .key_r          (rx_grp_eui),
    .active_r       (active_r),
    .free_ok        (free_ok),
    .free_idx       (free_idx)
  );

  assign is_group = eui[`MAB_GROUP_BIT];
  assign is_null  = (eui == `MAB_NULL_EUI);

  always_comb begin
    next_state       = state;
    next_op          = op;
    next_eui         = eui;
    next_cfm_valid   = 1'b0;
    next_cfm_op      = cfm_op;
    next_cfm_success = cfm_success;
    next_ann_valid   = 1'b0;
    next_ann_add     = ann_add;
    next_ann_eui     = ann_eui;
    next_ann_mcst    = ann_mcst;
    wr_en            = 1'b0;
    wr_idx           = idx_a;
    wr_bound         = bound_a;
    wr_active        = active_a;
    clr_active_all   = 1'b0;
    case (state)
      mab_pkg::MAB_ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_op    = mab_pkg::mab_op_e'(req_op);
          next_eui   = req_eui;
          next_state = mab_pkg::MAB_ST_EXEC;
        end
      end
      mab_pkg::MAB_ST_EXEC: begin
        next_cfm_valid   = 1'b1;
        next_cfm_op      = op;
        next_cfm_success = 1'b0;
        next_state       = mab_pkg::MAB_ST_DONE;
        case (op)
          mab_pkg::MAB_OP_REGISTER: begin
            if (!is_group) begin
              next_cfm_success = 1'b0;
            end else if (bound_a) begin
              next_cfm_success = 1'b1;
            end else if (hit_a || free_ok) begin
              wr_en            = 1'b1;
              wr_idx           = hit_a ? idx_a : free_idx;
              wr_bound         = 1'b1;
              wr_active        = active_a;
              next_cfm_success = 1'b1;
              next_ann_valid   = 1'b1;
              next_ann_add     = 1'b1;
              next_ann_eui     = eui;
              next_ann_mcst    = mcst_of(wr_idx);
            end else begin
              next_cfm_success = 1'b0;
            end
          end
          mab_pkg::MAB_OP_DEREGISTER: begin
            if (is_group && bound_a) begin
              wr_en            = 1'b1;
              wr_bound         = 1'b0;
              next_cfm_success = 1'b1;
              next_ann_valid   = 1'b1;
              next_ann_add     = 1'b0;
              next_ann_eui     = eui;
              next_ann_mcst    = mcst_of(idx_a);
            end
            next_cfm_op = op;
          end
          mab_pkg::MAB_OP_ACTIVATE: begin
            if (is_group && (hit_a || free_ok)) begin
              wr_en            = 1'b1;
              wr_idx           = hit_a ? idx_a : free_idx;
              wr_bound         = bound_a;
              wr_active        = 1'b1;
              next_cfm_success = 1'b1;
            end
            next_cfm_op = op;
          end
          mab_pkg::MAB_OP_DEACTIVATE: begin
            if (is_null) begin
              clr_active_all   = 1'b1;
              next_cfm_success = 1'b1;
            end else if (is_group) begin
              wr_en            = hit_a;
              wr_active        = 1'b0;
              next_cfm_success = 1'b1;
            end
            next_cfm_op = op;
          end
          default: begin
            next_cfm_success = 1'b0;
          end
        endcase
      end
      mab_pkg::MAB_ST_DONE: begin
        next_state = mab_pkg::MAB_ST_IDLE;
      end
      default: begin
        next_state = mab_pkg::MAB_ST_IDLE;
      end
    endcase
    // Ready is registered, so a request is never taken while busy.
    next_req_ready = (next_state == mab_pkg::MAB_ST_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state       <= mab_pkg::MAB_ST_IDLE;
      op          <= mab_pkg::MAB_OP_REGISTER;
      eui         <= `MAB_EUI_ZERO;
      req_ready   <= 1'b0;
      cfm_valid   <= 1'b0;
      cfm_op      <= mab_pkg::MAB_OP_REGISTER;
      cfm_success <= 1'b0;
      ann_valid   <= 1'b0;
      ann_add     <= 1'b0;
      ann_eui     <= `MAB_EUI_ZERO;
      ann_mcst    <= `MAB_MCST_ZERO;
    end else begin
      state       <= next_state;
      op          <= next_op;
      eui         <= next_eui;
      req_ready   <= next_req_ready;
      cfm_valid   <= next_cfm_valid;
      cfm_op      <= next_cfm_op;
      cfm_success <= next_cfm_success;
      ann_valid   <= next_ann_valid;
      ann_add     <= next_ann_add;
      ann_eui     <= next_ann_eui;
      ann_mcst    <= next_ann_mcst;
    end
  end

  // Data path lookups, one cycle each.
  logic                   next_tx_out_valid;
  logic                   next_tx_bound;
  logic [`MAB_MCST_W-1:0] next_tx_dest_mcst;
  logic                   next_rx_deliver;
  logic                   next_rx_discard;

  always_comb begin
    next_tx_out_valid = tx_valid;
    next_tx_bound     = tx_valid && bound_t;
    next_tx_dest_mcst = (tx_valid && bound_t) ? mcst_of(idx_t)
                                              : `MAB_MCST_ZERO;
    next_rx_deliver   = rx_valid && active_r;
    next_rx_discard   = rx_valid && !active_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_out_valid <= 1'b0;
      tx_bound     <= 1'b0;
      tx_dest_mcst <= `MAB_MCST_ZERO;
      rx_deliver   <= 1'b0;
      rx_discard   <= 1'b0;
    end else begin
      tx_out_valid <= next_tx_out_valid;
      tx_bound     <= next_tx_bound;
      tx_dest_mcst <= next_tx_dest_mcst;
      rx_deliver   <= next_rx_deliver;
      rx_discard   <= next_rx_discard;
    end
  end

endmodule

// ===== sim/mab_mgmt_model.sv
// Management entity model: issues requests and collects confirms.
`timescale 1ns/100ps
`include "mab_defs.svh"

module mab_mgmt_model (
  // Clock
  input  wire logic                  mclk,
  // Request
  output logic                       req_valid,
  output logic [`MAB_OP_W-1:0]       req_op,
  output logic [`MAB_EUI_W-1:0]      req_eui,
  input  wire logic                  req_ready,
  // Confirm
  input  wire logic                  cfm_valid,
  input  wire logic [`MAB_OP_W-1:0]  cfm_op,
  input  wire logic                  cfm_success
);
  initial begin
    req_valid = 1'h0;
    req_op    = 2'h0;
    req_eui   = `MAB_EUI_ZERO;
  end

  task automatic issue(input logic [`MAB_OP_W-1:0] op,
                       input logic [`MAB_EUI_W-1:0] eui,
                       output logic v, output logic [`MAB_OP_W-1:0] o,
                       output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    req_valid = 1'h1;
    req_op    = op;
    req_eui   = eui;
    @(negedge mclk);
    while (req_ready !== 1'h1 && n < 50) begin
      n++;
      @(negedge mclk);
    end
    @(posedge mclk);
    #1;
    req_valid = 1'h0;
    // A released bus shows the inverse so stale values cannot match.
    req_op    = ~op;
    req_eui   = ~eui;
    // The confirm pulse stands only between the first and second edge after.
    @(posedge mclk);
    #1;
    v  = cfm_valid;
    o  = cfm_op;
    ok = cfm_success;
  endtask
endmodule

// ===== sim/mab_top_asserts.sv
// Concurrent checks on the ports of the binding engine.
`timescale 1ns/100ps
`include "mab_defs.svh"

module mab_top_asserts (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Management
  input  wire logic                  req_valid,
  input  wire logic [`MAB_OP_W-1:0]  req_op,
  input  wire logic [`MAB_EUI_W-1:0] req_eui,
  input  wire logic                  req_ready,
  input  wire logic                  cfm_valid,
  input  wire logic                  cfm_success,
  // Beacon notice
  input  wire logic                  ann_valid,
  input  wire logic                  ann_add,
  input  wire logic [`MAB_MCST_W-1:0] ann_mcst,
  // Data path
  input  wire logic                  tx_valid,
  input  wire logic                  tx_out_valid,
  input  wire logic                  tx_bound,
  input  wire logic [`MAB_MCST_W-1:0] tx_dest_mcst,
  input  wire logic                  rx_valid,
  input  wire logic                  rx_deliver,
  input  wire logic                  rx_discard
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_busy;
    !req_ready ##1 !req_ready ##1 req_ready;
  endsequence

  cfm_latency_a: assert property (s_take |-> ##2 cfm_valid)
    else $error("confirm not two cycles after request");
  cfm_cause_a: assert property (cfm_valid |-> $past(req_valid && req_ready, 2))
    else $error("confirm without request");
  cfm_pulse_a: assert property (cfm_valid |=> !cfm_valid)
    else $error("confirm longer than one cycle");
  ready_gap_a: assert property (s_take |=> s_busy)
    else $error("ready spacing wrong");
  ann_with_cfm_a: assert property (ann_valid |-> cfm_valid && cfm_success)
    else $error("notice without successful confirm");
  ann_addr_a: assert property (ann_valid && ann_add |->
    (ann_mcst & 16'hFFF8) == `MAB_MCST_BASE)
    else $error("bound short address outside pool");
  bad_group_a: assert property ((s_take and !req_eui[`MAB_GROUP_BIT]) |->
    ##2 cfm_valid && !cfm_success)
    else $error("invalid group not failed");
  tx_answer_a: assert property (tx_valid |=> tx_out_valid)
    else $error("tx lookup not answered");
  tx_unbound_a: assert property (tx_out_valid && !tx_bound |->
    tx_dest_mcst == `MAB_MCST_ZERO)
    else $error("unbound tx carries address");
  rx_one_a: assert property (rx_valid |=> rx_deliver ^ rx_discard)
    else $error("rx verdict not exactly one");
  rx_quiet_a: assert property (!rx_valid |=> !rx_deliver && !rx_discard)
    else $error("rx verdict without frame");
endmodule

bind mab_top mab_top_asserts chk_u (
  .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
  .req_eui(req_eui), .req_ready(req_ready), .cfm_valid(cfm_valid),
  .cfm_success(cfm_success), .ann_valid(ann_valid), .ann_add(ann_add),
  .ann_mcst(ann_mcst), .tx_valid(tx_valid), .tx_out_valid(tx_out_valid),
  .tx_bound(tx_bound), .tx_dest_mcst(tx_dest_mcst), .rx_valid(rx_valid),
  .rx_deliver(rx_deliver), .rx_discard(rx_discard)
);

// ===== sim/multicast_address_binding_bench.sv
// Self-checking bench for the multicast address binding engine.
`timescale 1ns/100ps
`include "mab_defs.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module multicast_address_binding_bench;
  logic mclk, rst, req_valid, req_ready, cfm_valid, cfm_success;
  logic ann_valid, ann_add, tx_valid, tx_out_valid, tx_bound;
  logic rx_valid, rx_deliver, rx_discard;
  logic [`MAB_OP_W-1:0]   req_op, cfm_op;
  logic [`MAB_EUI_W-1:0]  req_eui, ann_eui, tx_eui, rx_grp_eui;
  logic [`MAB_MCST_W-1:0] ann_mcst, tx_dest_mcst;
  int n_fail = 0;
  int num_checks = 0;
  localparam logic [1:0] REG = mab_pkg::MAB_OP_REGISTER;
  localparam logic [1:0] DRG = mab_pkg::MAB_OP_DEREGISTER;
  localparam logic [1:0] ACT = mab_pkg::MAB_OP_ACTIVATE;
  localparam logic [1:0] DCT = mab_pkg::MAB_OP_DEACTIVATE;

  mab_top dut_u (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_op(req_op), .req_eui(req_eui), .req_ready(req_ready),
    .cfm_valid(cfm_valid), .cfm_op(cfm_op), .cfm_success(cfm_success),
    .ann_valid(ann_valid), .ann_add(ann_add), .ann_eui(ann_eui),
    .ann_mcst(ann_mcst), .tx_valid(tx_valid), .tx_eui(tx_eui),
    .tx_out_valid(tx_out_valid), .tx_bound(tx_bound),
    .tx_dest_mcst(tx_dest_mcst), .rx_valid(rx_valid),
    .rx_grp_eui(rx_grp_eui), .rx_deliver(rx_deliver),
    .rx_discard(rx_discard));

  mab_mgmt_model mgmt_u (.mclk(mclk), .req_valid(req_valid),
    .req_op(req_op), .req_eui(req_eui), .req_ready(req_ready),
    .cfm_valid(cfm_valid), .cfm_op(cfm_op), .cfm_success(cfm_success));

  function automatic logic [47:0] grp(input int i);
    return 48'h0100_0000_0010 + 48'(i);
  endfunction

  function automatic logic [15:0] mc(input int i);
    return `MAB_MCST_BASE | 16'(i);
  endfunction

  task automatic req(input logic [1:0] op, input logic [47:0] e,
                     input logic ok);
    logic v, s;
    logic [1:0] o;
    mgmt_u.issue(op, e, v, o, s);
    `CHK("cfm_valid", 1'h1, v)
    `CHK("cfm_op", op, o)
    `CHK("cfm_success", ok, s)
  endtask

  task automatic ann_chk(input logic v, input logic a, input logic [47:0] e,
                         input logic [15:0] m);
    `CHK("ann_valid", v, ann_valid)
    if (v) begin
      `CHK("ann_add", a, ann_add)
      `CHK("ann_eui", e, ann_eui)
      `CHK("ann_mcst", m, ann_mcst)
    end
  endtask

  task automatic tx_chk(input logic [47:0] e, input logic b,
                        input logic [15:0] m);
    @(posedge mclk);
    #1;
    tx_valid = 1'h1;
    tx_eui   = e;
    @(posedge mclk);
    #1;
    tx_valid = 1'h0;
    tx_eui   = ~e;
    `CHK("tx_out_valid", 1'h1, tx_out_valid)
    `CHK("tx_bound", b, tx_bound)
    `CHK("tx_dest_mcst", m, tx_dest_mcst)
  endtask

  task automatic rx_chk(input logic [47:0] e, input logic d);
    @(posedge mclk);
    #1;
    rx_valid   = 1'h1;
    rx_grp_eui = e;
    @(posedge mclk);
    #1;
    rx_valid   = 1'h0;
    rx_grp_eui = ~e;
    `CHK("rx_deliver", d, rx_deliver)
    `CHK("rx_discard", ~d, rx_discard)
  endtask

  task automatic t_register;
    for (int i = 0; i < 8; i++) begin
      req(REG, grp(i), 1'h1);
      ann_chk(1'h1, 1'h1, grp(i), mc(i));
    end
    req(REG, grp(8), 1'h0);
    ann_chk(1'h0, 1'h0, grp(8), 16'h0000);
    req(REG, grp(2), 1'h1);
    ann_chk(1'h0, 1'h0, grp(2), 16'h0000);
  endtask

  task automatic t_transmit;
    for (int i = 0; i < 8; i++) begin
      tx_chk(grp(i), 1'h1, mc(i));
    end
    tx_chk(grp(8), 1'h0, `MAB_MCST_ZERO);
  endtask

  task automatic t_deregister;
    req(DRG, grp(3), 1'h1);
    ann_chk(1'h1, 1'h0, grp(3), mc(3));
    tx_chk(grp(3), 1'h0, `MAB_MCST_ZERO);
    req(DRG, grp(3), 1'h0);
    req(REG, grp(9), 1'h1);
    ann_chk(1'h1, 1'h1, grp(9), mc(3));
  endtask

  task automatic t_receive;
    rx_chk(grp(0), 1'h0);
    req(ACT, grp(0), 1'h1);
    rx_chk(grp(0), 1'h1);
    req(ACT, grp(1), 1'h1);
    req(DCT, grp(0), 1'h1);
    rx_chk(grp(0), 1'h0);
    rx_chk(grp(1), 1'h1);
    req(ACT, grp(0), 1'h1);
    req(DCT, `MAB_NULL_EUI, 1'h1);
    rx_chk(grp(0), 1'h0);
    rx_chk(grp(1), 1'h0);
    req(REG, 48'h0200_0000_0001, 1'h0);
    req(ACT, 48'h0200_0000_0001, 1'h0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  initial begin
    rst        = 1'h1;
    tx_valid   = 1'h0;
    tx_eui     = `MAB_EUI_ZERO;
    rx_valid   = 1'h0;
    rx_grp_eui = `MAB_EUI_ZERO;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'h0;
    t_register();
    t_transmit();
    t_deregister();
    t_receive();
    stop_test();
  end
endmodule
